/* File: hdl/slpt_pkg.sv */
// Notes on behaviour
// - Telegram is sync zero, 3 command bits, parity, 4 address bits, parity.
// - Write adds 14 data bits and parity; acknowledge only for valid processed telegram.
// - Read reply is acknowledge, 14 data bits, then data parity on output.
// - Activate pulse selects one deactivated device; only it accepts commands.
// - Supply bit time measured from sync bit; programmer uses 1.7 to 1.8 ms.
// - Every accepted telegram answered by zero acknowledge setting output bit time 2 to 4 ms.
// - Logical one has extra transition between 50 and 80 percent of bit.
// - Command parity is one when command holds odd count of zeros.
// - Address parity is one when address holds odd count of zeros.
// - Data parity is one when data holds even count of zeros.
// - Write takes register value from trailing bits of data field.
// - Read places register value in leading bits of data field.
// - Command is binary; code 2 reads, code 3 writes a register.
// - Code 4 programs, code 5 erases nonvolatile registers except lock bits.
// - Code 6 sets factory lock; code 7 locks device into analog mode.
// - Factory lock set on delivery and never cleared.
// - Fields travel most significant bit first.
// - Zero has no inner transition; every bit ends with a transition.
// - Writing 2063 to deactivation register deactivates until activate pulse or reset.
package slpt_pkg;
	localparam int CLK_KHZ = 40000;
	localparam int SYNC_MIN_US = 1700;
	localparam int SYNC_MAX_US = 1800;
	localparam int SYNC_MIN_CYC = (SYNC_MIN_US * CLK_KHZ + 999) / 1000;
	localparam int SYNC_MAX_CYC = SYNC_MAX_US * CLK_KHZ / 1000;
	localparam int OUT_BIT_MIN_US = 2000;
	localparam int OUT_BIT_TYP_US = 3000;
	localparam int OUT_BIT_MAX_US = 4000;
	localparam int OUT_BIT_MIN_CYC = (OUT_BIT_MIN_US * CLK_KHZ + 999) / 1000;
	localparam int OUT_BIT_TYP_CYC = OUT_BIT_TYP_US * CLK_KHZ / 1000;
	localparam int OUT_BIT_MAX_CYC = OUT_BIT_MAX_US * CLK_KHZ / 1000;
	localparam int ACT_MIN_US = 50;
	localparam int ACT_MIN_CYC = (ACT_MIN_US * CLK_KHZ + 999) / 1000;

	localparam int CNT_W = 18;
	localparam int ACT_W = 12;
	localparam int CMD_W = 3;
	localparam int ADR_W = 4;
	localparam int DAT_W = 14;
	localparam int NREG = 16;
	localparam logic [4:0] SHORT_BITS = 5'h09;
	localparam logic [4:0] LONG_BITS = 5'h18;
	localparam logic [4:0] REPLY_BITS = 5'h10;
	localparam logic [4:0] ACK_BITS = 5'h01;

	localparam logic [CMD_W-1:0] CMD_READ = 3'h2;
	localparam logic [CMD_W-1:0] CMD_WRITE = 3'h3;
	localparam logic [CMD_W-1:0] CMD_PROG = 3'h4;
	localparam logic [CMD_W-1:0] CMD_ERASE = 3'h5;
	localparam logic [CMD_W-1:0] CMD_FLOCK = 3'h6;
	localparam logic [CMD_W-1:0] CMD_LOCK = 3'h7;

	localparam logic [ADR_W-1:0] ADR_LOCK = 4'h6;
	localparam logic [ADR_W-1:0] ADR_ADC = 4'h7;
	localparam logic [ADR_W-1:0] ADR_FLOCK = 4'hE;
	localparam logic [ADR_W-1:0] ADR_DEACT = 4'hF;
	localparam logic [DAT_W-1:0] DEACT_KEY = 14'h080F;
	localparam logic [3:0] REG_WIDTH [0:NREG-1] = '{4'h0, 4'hA, 4'hB, 4'hB,
		4'hE, 4'h6, 4'h1, 4'hE, 4'h4, 4'h5, 4'h0, 4'h6, 4'h5, 4'h6, 4'h1,
		4'hC};
	localparam logic [NREG-1:0] CUST_WR = 16'h183E;
	localparam logic [NREG-1:0] NV_MASK = 16'h3B3E;
	localparam logic [NREG-1:0] BUS_WR_MASK = 16'h2380;
	localparam logic FLOCK_RESET = 1'b1;

	localparam int BUS_AW = 6;
	localparam int BUS_DW = 32;
	localparam logic [BUS_AW-1:0] BUS_STATUS = 6'h10;
	localparam logic [BUS_AW-1:0] BUS_REPLY_TIME = 6'h11;
	localparam logic [1:0] BUS_REG_PAGE = 2'h0;
	localparam logic [1:0] BUS_NV_PAGE = 2'h2;
	localparam int ST_DEACT = 0;
	localparam int ST_LOCK = 1;
	localparam int ST_FLOCK = 2;
	localparam int ST_ARMED = 3;
	localparam int ST_RX_BUSY = 4;
	localparam int ST_TX_BUSY = 5;
	localparam int ST_PAR_ERR = 6;

	typedef enum logic [1:0] {RX_IDLE, RX_SYNC, RX_BITS, RX_EXEC} slpt_rx_t;

	function automatic logic [DAT_W-1:0] slpt_mask(input logic [3:0] w);
		logic [DAT_W:0] one;
		one = 15'h0001;
		return DAT_W'((one << w) - one);
	endfunction : slpt_mask
endpackage : slpt_pkg

/* File: hdl/slpt_zero_parity.sv */
`timescale 1ns/100ps
`default_nettype none
module slpt_zero_parity #(
	parameter int W = 3,
	parameter bit ONE_ON_EVEN = 1'b0
) (
	input wire logic [W-1:0] bits,
	output logic parity
);
	if (W < 1) begin : g_bad_width
		$error("slpt_zero_parity: width must be at least one");
	end
	// Reduction of inverted bits is one for an odd count of zeros
	assign parity = (^(~bits)) ^ ONE_ON_EVEN;
endmodule : slpt_zero_parity
`default_nettype wire

/* File: hdl/slpt_device.sv */
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module slpt_device import slpt_pkg::*; #(
	parameter int SYNC_MIN = SYNC_MIN_CYC,
	parameter int SYNC_MAX = SYNC_MAX_CYC,
	parameter int REPLY_TIME = OUT_BIT_TYP_CYC,
	parameter int REPLY_MIN = OUT_BIT_MIN_CYC,
	parameter int REPLY_MAX = OUT_BIT_MAX_CYC
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic supply_level,
	input wire logic prog_level,
	input wire logic out_in,
	output logic out_o,
	output logic out_oe_n,
	output logic analog_mode,
	input wire logic [BUS_AW-1:0] bus_addr,
	input wire logic [BUS_DW-1:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output logic [BUS_DW-1:0] bus_rdata
);
	if (SYNC_MIN < 2 || SYNC_MIN > SYNC_MAX || 2 * SYNC_MAX >= 2 ** CNT_W ||
		REPLY_MIN < 8 || REPLY_MIN > REPLY_TIME || REPLY_TIME > REPLY_MAX ||
		REPLY_MAX >= 2 ** CNT_W) begin : g_bad_params
		$error("slpt_device: timing parameters out of range");
	end

	localparam logic [CNT_W-1:0] SYNC_LO = CNT_W'(SYNC_MIN - 1);
	localparam logic [CNT_W-1:0] SYNC_HI = CNT_W'(SYNC_MAX - 1);
	localparam logic [CNT_W-1:0] SYNC_END = CNT_W'(SYNC_MAX);
	localparam logic [CNT_W-1:0] RP_RESET = CNT_W'(REPLY_TIME);
	localparam logic [CNT_W-1:0] RP_LO = CNT_W'(REPLY_MIN);
	localparam logic [CNT_W-1:0] RP_HI = CNT_W'(REPLY_MAX);
	localparam logic [ACT_W-1:0] ACT_MIN_C = ACT_W'(ACT_MIN_CYC);

	function automatic logic [DAT_W-1:0] reg_view(input logic [ADR_W-1:0] a,
		input logic [DAT_W-1:0] r, input logic lk, input logic fl);
		logic [DAT_W-1:0] v;
		v = r;
		if (a == ADR_LOCK) begin
			v = {{(DAT_W-1){1'b0}}, lk};
		end else if (a == ADR_FLOCK) begin
			v = {{(DAT_W-1){1'b0}}, fl};
		end else if (a == ADR_DEACT) begin
			v = '0;
		end
		return v;
	endfunction : reg_view

	// Pin synchronisers, stage two feeds logic, stage three detects edges
	logic [2:0] sup_q;
	logic [2:0] prg_q;
	logic [1:0] oin_q;
	logic sup_edge;
	logic prog_rise;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			sup_q <= '0;
			prg_q <= '0;
			oin_q <= '0;
		end else begin
			sup_q <= {sup_q[1:0], supply_level};
			prg_q <= {prg_q[1:0], prog_level};
			oin_q <= {oin_q[0], out_in};
		end
	end
	assign sup_edge = sup_q[2] ^ sup_q[1];
	assign prog_rise = prg_q[1] & ~prg_q[2];

	// Telegram receiver
	slpt_rx_t rx_state;
	logic [CNT_W-1:0] rx_cnt;
	logic [CNT_W-1:0] bit_time;
	logic rx_mid;
	logic [4:0] rx_n;
	logic [LONG_BITS-1:0] rx_sh;
	logic rx_long;
	logic [CNT_W-1:0] one_limit;
	logic [CNT_W-1:0] bit_timeout;
	logic [LONG_BITS-1:0] next_sh;
	logic [4:0] next_n;

	// Inner edges before 7/8 of the bit mark a one; 80% leaves margin
	assign one_limit = bit_time - (bit_time >> 3);
	assign bit_timeout = bit_time << 1;
	assign next_sh = {rx_sh[LONG_BITS-2:0], rx_mid};
	assign next_n = rx_n + 5'h01;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rx_state <= RX_IDLE;
			rx_cnt <= '0;
			bit_time <= RP_RESET;
			rx_mid <= 1'b0;
			rx_n <= '0;
			rx_sh <= '0;
			rx_long <= 1'b0;
		end else begin
			case (rx_state)
			RX_IDLE: begin
				rx_cnt <= '0;
				if (sup_edge) begin
					rx_state <= RX_SYNC;
				end
			end
			RX_SYNC: begin
				if (sup_edge) begin
					rx_cnt <= '0;
					if (rx_cnt >= SYNC_LO && rx_cnt <= SYNC_HI) begin
						bit_time <= rx_cnt + 1'b1;
						rx_state <= RX_BITS;
						rx_n <= '0;
						rx_mid <= 1'b0;
						rx_sh <= '0;
					end
				end else if (rx_cnt == SYNC_END) begin
					rx_state <= RX_IDLE;
				end else begin
					rx_cnt <= rx_cnt + 1'b1;
				end
			end
			RX_BITS: begin
				if (sup_edge && rx_cnt < one_limit) begin
					rx_mid <= 1'b1;
					rx_cnt <= rx_cnt + 1'b1;
					if (rx_mid) begin
						rx_state <= RX_IDLE;
					end
				end else if (sup_edge) begin
					rx_sh <= next_sh;
					rx_n <= next_n;
					rx_mid <= 1'b0;
					rx_cnt <= '0;
					if (next_n == SHORT_BITS && next_sh[8:6] != CMD_WRITE) begin
						rx_long <= 1'b0;
						rx_state <= RX_EXEC;
					end else if (next_n == LONG_BITS) begin
						rx_long <= 1'b1;
						rx_state <= RX_EXEC;
					end
				end else if (rx_cnt >= bit_timeout) begin
					rx_state <= RX_IDLE;
				end else begin
					rx_cnt <= rx_cnt + 1'b1;
				end
			end
			RX_EXEC: begin
				rx_state <= RX_IDLE;
			end
			default: begin
				rx_state <= RX_IDLE;
			end
			endcase
		end
	end

	logic [CMD_W-1:0] f_cmd;
	logic f_cp;
	logic [ADR_W-1:0] f_adr;
	logic f_ap;
	logic [DAT_W-1:0] f_data;
	logic f_dp;
	assign f_cmd = rx_long ? rx_sh[23:21] : rx_sh[8:6];
	assign f_cp = rx_long ? rx_sh[20] : rx_sh[5];
	assign f_adr = rx_long ? rx_sh[19:16] : rx_sh[4:1];
	assign f_ap = rx_long ? rx_sh[15] : rx_sh[0];
	assign f_data = rx_sh[14:1];
	assign f_dp = rx_sh[0];

	logic cp_calc;
	logic ap_calc;
	logic dp_calc;
	logic rd_par;
	logic [DAT_W-1:0] rd_left;

	slpt_zero_parity #(.W(CMD_W), .ONE_ON_EVEN(1'b0)) u_cp (
		.bits(f_cmd),
		.parity(cp_calc)
	);
	slpt_zero_parity #(.W(ADR_W), .ONE_ON_EVEN(1'b0)) u_ap (
		.bits(f_adr),
		.parity(ap_calc)
	);
	slpt_zero_parity #(.W(DAT_W), .ONE_ON_EVEN(1'b1)) u_dp (
		.bits(f_data),
		.parity(dp_calc)
	);
	slpt_zero_parity #(.W(DAT_W), .ONE_ON_EVEN(1'b1)) u_rp (
		.bits(rd_left),
		.parity(rd_par)
	);

	logic deact;
	logic flock;
	logic prog_arm;
	logic [CMD_W-1:0] prog_op;
	logic par_err;
	logic tx_busy;
	logic exec;
	logic par_ok;
	logic accept;
	logic [DAT_W-1:0] ram [0:NREG-1];
	logic [DAT_W-1:0] nv [0:NREG-1];

	assign exec = rx_state == RX_EXEC;
	assign par_ok = f_cp == cp_calc && f_ap == ap_calc &&
		(!rx_long || f_dp == dp_calc);
	assign accept = exec && par_ok && f_cmd >= CMD_READ && !deact &&
		!analog_mode && !tx_busy;

	// value left aligned in data field
	assign rd_left = reg_view(f_adr, ram[f_adr], analog_mode, flock) <<
		(4'(DAT_W) - REG_WIDTH[f_adr]);

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < NREG; i++) begin
				ram[i] <= '0;
			end
		end else begin
			if (accept && f_cmd == CMD_WRITE && CUST_WR[f_adr]) begin
				ram[f_adr] <= f_data & slpt_mask(REG_WIDTH[f_adr]);
			end
			// Trim and measurement words arrive from the chip side
			if (bus_wr && bus_addr[5:4] == BUS_REG_PAGE &&
				BUS_WR_MASK[bus_addr[3:0]]) begin
				ram[bus_addr[3:0]] <= bus_wdata[DAT_W-1:0] &
					slpt_mask(REG_WIDTH[bus_addr[3:0]]);
			end
		end
	end

	// Nonvolatile commands wait for the programming level
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			prog_arm <= 1'b0;
			prog_op <= '0;
		end else if (accept && f_cmd >= CMD_PROG) begin
			prog_arm <= 1'b1;
			prog_op <= f_cmd;
		end else if (prog_rise || rx_state == RX_SYNC) begin
			prog_arm <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < NREG; i++) begin
				nv[i] <= '0;
			end
		end else if (prog_rise && prog_arm) begin
			for (int i = 0; i < NREG; i++) begin
				if (NV_MASK[i] && prog_op == CMD_PROG) begin
					nv[i] <= ram[i];
				end else if (NV_MASK[i] && prog_op == CMD_ERASE) begin
					nv[i] <= '0;
				end
			end
		end
	end

	// Locks are one-way; only reset clears analog mode, and reset sets factory lock
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			analog_mode <= 1'b0;
			flock <= FLOCK_RESET;
		end else if (prog_rise && prog_arm) begin
			if (prog_op == CMD_LOCK) begin
				analog_mode <= 1'b1;
			end
			if (prog_op == CMD_FLOCK) begin
				flock <= 1'b1;
			end
		end
	end

	// Activate pulse watch while the pin is released
	logic [ACT_W-1:0] act_cnt;
	logic act_fire;
	assign act_fire = deact && out_oe_n && !oin_q[1] && act_cnt >= ACT_MIN_C;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			act_cnt <= '0;
		end else if (deact && out_oe_n && oin_q[1]) begin
			if (act_cnt != {ACT_W{1'b1}}) begin
				act_cnt <= act_cnt + 1'b1;
			end
		end else begin
			act_cnt <= '0;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			deact <= 1'b0;
		end else if (accept && f_cmd == CMD_WRITE && f_adr == ADR_DEACT &&
			f_data == DEACT_KEY) begin
			deact <= 1'b1;
		end else if (act_fire) begin
			deact <= 1'b0;
		end
	end

	// Reply transmitter on the output pin
	logic [CNT_W-1:0] rp_time;
	logic [CNT_W-1:0] rp_mid;
	logic [CNT_W-1:0] tx_cnt;
	logic [REPLY_BITS-1:0] tx_sh;
	logic [4:0] tx_n;
	// Inner edge near 65% from shifts, avoiding a divider
	assign rp_mid = (rp_time >> 1) + (rp_time >> 3) + (rp_time >> 5);

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rp_time <= RP_RESET;
		end else if (bus_wr && bus_addr == BUS_REPLY_TIME && !tx_busy &&
			bus_wdata[CNT_W-1:0] >= RP_LO && bus_wdata[CNT_W-1:0] <= RP_HI &&
			bus_wdata[BUS_DW-1:CNT_W] == '0) begin
			rp_time <= bus_wdata[CNT_W-1:0];
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			tx_busy <= 1'b0;
			out_o <= 1'b0;
			out_oe_n <= 1'b1;
			tx_cnt <= '0;
			tx_sh <= '0;
			tx_n <= '0;
		end else if (!tx_busy) begin
			if (accept) begin
				tx_busy <= 1'b1;
				out_oe_n <= 1'b0;
				out_o <= 1'b1;
				tx_cnt <= '0;
				if (f_cmd == CMD_READ) begin
					tx_sh <= {1'b0, rd_left, rd_par};
					tx_n <= REPLY_BITS;
				end else begin
					tx_sh <= '0;
					tx_n <= ACK_BITS;
				end
			end
		end else begin
			tx_cnt <= tx_cnt + 1'b1;
			if (tx_cnt == rp_mid && tx_sh[REPLY_BITS-1]) begin
				out_o <= ~out_o;
			end
			if (tx_cnt == rp_time - 1'b1) begin
				out_o <= ~out_o;
				tx_cnt <= '0;
				tx_sh <= tx_sh << 1;
				tx_n <= tx_n - 5'h01;
				if (tx_n == ACK_BITS) begin
					tx_busy <= 1'b0;
					out_oe_n <= 1'b1;
					out_o <= 1'b0;
				end
			end
		end
	end

	// Sticky error; a new failure beats the clearing read
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			par_err <= 1'b0;
		end else if (exec && !par_ok) begin
			par_err <= 1'b1;
		end else if (bus_rd && bus_addr == BUS_STATUS) begin
			par_err <= 1'b0;
		end
	end

	logic [BUS_DW-1:0] status;
	always_comb begin
		status = '0;
		status[ST_DEACT] = deact;
		status[ST_LOCK] = analog_mode;
		status[ST_FLOCK] = flock;
		status[ST_ARMED] = prog_arm;
		status[ST_RX_BUSY] = rx_state != RX_IDLE;
		status[ST_TX_BUSY] = tx_busy;
		status[ST_PAR_ERR] = par_err;
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			bus_rdata <= '0;
		end else if (!bus_rd) begin
			bus_rdata <= '0;
		end else if (bus_addr[5:4] == BUS_REG_PAGE) begin
			bus_rdata <= {{(BUS_DW-DAT_W){1'b0}}, reg_view(bus_addr[3:0],
				ram[bus_addr[3:0]], analog_mode, flock)};
		end else if (bus_addr[5:4] == BUS_NV_PAGE) begin
			bus_rdata <= {{(BUS_DW-DAT_W){1'b0}}, nv[bus_addr[3:0]]};
		end else if (bus_addr == BUS_STATUS) begin
			bus_rdata <= status;
		end else if (bus_addr == BUS_REPLY_TIME) begin
			bus_rdata <= {{(BUS_DW-CNT_W){1'b0}}, rp_time};
		end else begin
			bus_rdata <= '0;
		end
	end
endmodule : slpt_device
`default_nettype wire

/* File: tb/slpt_device_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module slpt_device_assertions import slpt_pkg::*; #(
	parameter int REPLY_MAX = OUT_BIT_MAX_CYC
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic prog_level,
	input wire logic out_o,
	input wire logic out_oe_n,
	input wire logic analog_mode,
	input wire logic [BUS_AW-1:0] bus_addr,
	input wire logic bus_rd,
	input wire logic [BUS_DW-1:0] bus_rdata
);
	logic [15:0] rp_cnt;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	// Cycles the pin has been driven
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rp_cnt <= '0;
		end else if (out_oe_n) begin
			rp_cnt <= '0;
		end else begin
			rp_cnt <= rp_cnt + 16'h0001;
		end
	end
	rdata_idle_a: assert property (
		!$past(bus_rd) |-> bus_rdata == '0)
		else $error("read data outside answer cycle");
	unmapped_zero_a: assert property (
		$past(bus_rd) && $past(bus_addr) >= 6'h30 |-> bus_rdata == '0)
		else $error("unmapped read not zero");
	released_low_a: assert property (out_oe_n |-> !out_o)
		else $error("released pin driven high");
	ack_start_a: assert property ($fell(out_oe_n) |-> out_o)
		else $error("reply without start edge");
	ack_zero_a: assert property (
		$fell(out_oe_n) |-> (out_o && !out_oe_n) [*8])
		else $error("acknowledge not a steady zero");
	bit_edge_a: assert property (
		$changed(out_o) && !out_oe_n |=> $stable(out_o) [*8])
		else $error("reply edges too close");
	reply_len_a: assert property (
		rp_cnt <= 16'(16 * REPLY_MAX))
		else $error("reply longer than sixteen bits");
	lock_hold_a: assert property (analog_mode |=> analog_mode)
		else $error("lock dropped");
	lock_quiet_a: assert property (
		analog_mode && out_oe_n |=> out_oe_n)
		else $error("locked device replied");
	lock_cause_a: assert property (
		$rose(analog_mode) |-> $past(prog_level))
		else $error("lock without programming level");
endmodule : slpt_device_assertions
bind slpt_device slpt_device_assertions #(.REPLY_MAX(REPLY_MAX))
	slpt_device_assertions_i (
	.sys_clk(sys_clk),
	.rstn(rstn),
	.prog_level(prog_level),
	.out_o(out_o),
	.out_oe_n(out_oe_n),
	.analog_mode(analog_mode),
	.bus_addr(bus_addr),
	.bus_rd(bus_rd),
	.bus_rdata(bus_rdata)
);
`default_nettype wire

/* File: tb/slpt_prog_model.sv */
`timescale 1ns/100ps
`default_nettype none
module slpt_prog_model #(
	parameter int BIT_T = 70,
	parameter int ONE_AT = 45,
	// Wait shortened: the device does not time it
	parameter int PROG_WAIT = 2000,
	parameter int PROG_HOLD = 200
) (
	input wire logic sys_clk,
	input wire logic pin,
	output logic supply_level,
	output logic prog_level,
	output logic act_drv
);
	initial begin
		supply_level = 1'h0;
		prog_level = 1'h0;
		act_drv = 1'h0;
	end
	task automatic toggle_after(input int n);
		repeat (n) @(posedge sys_clk);
		supply_level <= ~supply_level;
	endtask : toggle_after
	task automatic send(input logic [23:0] b, input int n);
		toggle_after(1);
		toggle_after(BIT_T);
		for (int i = 23; i > 23 - n; i--) begin
			if (b[i]) begin
				toggle_after(ONE_AT);
				toggle_after(BIT_T - ONE_AT);
			end else begin
				toggle_after(BIT_T);
			end
		end
	endtask : send
	task automatic get_reply(input int n, output logic [15:0] v,
		output int tp, output bit got);
		logic a;
		got = 1'b0;
		tp = 0;
		v = '0;
		for (int k = 0; k < 400 && !got; k++) begin
			@(negedge sys_clk);
			got = (pin === 1'h1);
		end
		while (got && pin === 1'h1 && tp < 1000) begin
			@(negedge sys_clk);
			tp++;
		end
		// Final edge may merge with release, so sample inside the bit
		for (int i = 0; i < n && got; i++) begin
			repeat (tp / 4) @(negedge sys_clk);
			a = pin;
			repeat (tp * 9 / 10 - tp / 4) @(negedge sys_clk);
			v = {v[14:0], a !== pin};
			repeat (tp - tp * 9 / 10) @(negedge sys_clk);
		end
	endtask : get_reply
	task automatic activate(input int n);
		@(posedge sys_clk);
		act_drv <= 1'h1;
		repeat (n) @(posedge sys_clk);
		act_drv <= 1'h0;
	endtask : activate
	task automatic prog_pulse();
		repeat (PROG_WAIT) @(posedge sys_clk);
		prog_level <= 1'h1;
		repeat (PROG_HOLD) @(posedge sys_clk);
		prog_level <= 1'h0;
	endtask : prog_pulse
endmodule : slpt_prog_model
`default_nettype wire

/* File: tb/slpt_device_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module slpt_device_tb import slpt_pkg::*;;
	logic sys_clk, rstn, supply_level, prog_level, act_drv, pin;
	logic out_o, out_oe_n, analog_mode, bus_wr, bus_rd;
	logic [BUS_AW-1:0] bus_addr;
	logic [BUS_DW-1:0] bus_wdata, bus_rdata;
	int miscompares, cmp_count, tp;
	logic [15:0] v;
	bit got;
	// Pulled-down pin
	assign pin = !out_oe_n ? out_o : act_drv;
	always #12.5 sys_clk = ~sys_clk;
	slpt_device #(.SYNC_MIN(68), .REPLY_TIME(120),
		.REPLY_MIN(80), .REPLY_MAX(160)) slpt_device_i (
		.sys_clk(sys_clk), .rstn(rstn), .supply_level(supply_level),
		.prog_level(prog_level), .out_in(pin), .out_o(out_o),
		.out_oe_n(out_oe_n), .analog_mode(analog_mode),
		.bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
		.bus_rd(bus_rd), .bus_rdata(bus_rdata));
	slpt_prog_model slpt_prog_model_i (
		.sys_clk(sys_clk), .pin(pin), .supply_level(supply_level),
		.prog_level(prog_level), .act_drv(act_drv));
	task automatic check(input string s, input logic [31:0] e,
		input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %s: expected %h, seen %h", s, e, g);
		end
	endtask : check
	task automatic bus_write(input logic [BUS_AW-1:0] a,
		input logic [BUS_DW-1:0] w);
		@(posedge sys_clk);
		bus_wr <= 1'h1;
		bus_addr <= a;
		bus_wdata <= w;
		@(posedge sys_clk);
		bus_wr <= 1'h0;
	endtask : bus_write
	task automatic rd_check(input string s, input logic [BUS_AW-1:0] a,
		input logic [BUS_DW-1:0] e);
		@(posedge sys_clk);
		bus_rd <= 1'h1;
		bus_addr <= a;
		@(posedge sys_clk);
		bus_rd <= 1'h0;
		@(negedge sys_clk);
		check(s, e, bus_rdata);
	endtask : rd_check
	task automatic tel(input logic [2:0] c, input logic [3:0] a,
		input logic [13:0] dt, input bit bad);
		logic [23:0] b;
		b = {c, 1'($countones(~c) % 2) ^ bad, a, 1'($countones(~a) % 2),
			dt, 1'($countones(~dt) % 2 == 0)};
		slpt_prog_model_i.send(b, c == CMD_WRITE ? 24 : 9);
		slpt_prog_model_i.get_reply(c == CMD_READ ? 15 : 0, v, tp, got);
		repeat (10) @(posedge sys_clk);
	endtask : tel
	task automatic prog_cmd(input logic [2:0] c);
		tel(c, 4'h0, 14'h0000, 1'b0);
		check("program ack", 32'h0000_0001, got);
		slpt_prog_model_i.prog_pulse();
		repeat (10) @(posedge sys_clk);
	endtask : prog_cmd
	task automatic t_reset();
		rd_check("status", BUS_STATUS, 32'h0000_0004);
		bus_write(6'h07, 32'hFFFF_FFFF);
		rd_check("trim reg 7", 6'h07, 32'h0000_3FFF);
		bus_write(BUS_REPLY_TIME, 32'h0000_0064);
		rd_check("reply time", BUS_REPLY_TIME, 32'h0000_0064);
		bus_write(BUS_REPLY_TIME, 32'h0000_0078);
		bus_write(BUS_REPLY_TIME, 32'h0000_0032);
		rd_check("reply time", BUS_REPLY_TIME, 32'h0000_0078);
		rd_check("unmapped", 6'h3F, 32'h0000_0000);
		$display("reset test done");
	endtask : t_reset
	task automatic t_write_read();
		tel(CMD_WRITE, 4'h1, 14'h3ABC, 1'b0);
		check("write ack", 32'h0000_0001, got);
		check("ack length", 32'h0000_0078, tp);
		rd_check("reg 1", 6'h01, 32'h0000_02BC);
		tel(CMD_READ, 4'h1, 14'h0000, 1'b0);
		check("read ack", 32'h0000_0001, got);
		check("read reply", 32'h0000_5781, v);
		$display("write read test done");
	endtask : t_write_read
	task automatic t_parity();
		tel(CMD_WRITE, 4'h2, 14'h0155, 1'b1);
		check("bad parity ack", 32'h0000_0000, got);
		rd_check("status", BUS_STATUS, 32'h0000_0044);
		rd_check("reg 2", 6'h02, 32'h0000_0000);
		tel(3'h1, 4'h2, 14'h0000, 1'b0);
		check("code 1 ack", 32'h0000_0000, got);
		$display("parity test done");
	endtask : t_parity
	task automatic t_nv();
		prog_cmd(CMD_PROG);
		rd_check("nv reg 1", 6'h21, 32'h0000_02BC);
		prog_cmd(CMD_ERASE);
		rd_check("nv reg 1", 6'h21, 32'h0000_0000);
		prog_cmd(CMD_FLOCK);
		rd_check("status", BUS_STATUS, 32'h0000_0004);
		$display("nonvolatile test done");
	endtask : t_nv
	task automatic t_deact();
		tel(CMD_WRITE, ADR_DEACT, DEACT_KEY, 1'b0);
		rd_check("status", BUS_STATUS, 32'h0000_0005);
		tel(CMD_READ, 4'h1, 14'h0000, 1'b0);
		check("deselected ack", 32'h0000_0000, got);
		slpt_prog_model_i.activate(4000);
		repeat (10) @(posedge sys_clk);
		rd_check("status", BUS_STATUS, 32'h0000_0004);
		$display("activate test done");
	endtask : t_deact
	task automatic t_lock();
		prog_cmd(CMD_LOCK);
		check("analog mode", 32'h0000_0001, analog_mode);
		tel(CMD_READ, 4'h1, 14'h0000, 1'b0);
		check("locked ack", 32'h0000_0000, got);
		$display("lock test done");
	endtask : t_lock
	task automatic report_and_stop();
		$display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		sys_clk = 1'h0;
		rstn = 1'h0;
		bus_wr = 1'h0;
		bus_rd = 1'h0;
		bus_addr = '0;
		bus_wdata = '0;
		repeat (16) @(posedge sys_clk);
		rstn <= 1'h1;
		t_reset();
		t_write_read();
		t_parity();
		t_nv();
		t_deact();
		t_lock();
		report_and_stop();
	end
	// Tests need about 28000 cycles
	initial begin
		repeat (100000) @(posedge sys_clk);
		miscompares++;
		report_and_stop();
	end
endmodule : slpt_device_tb
`default_nettype wire
